/* src/pdcs_err_gate.sv */
// Purpose: Gate error events onto message requests by their report enables
// Assumes: Events are one-cycle pulses
// Notes: Outputs are registered so each message request is one cycle late
`timescale 1ns/1ps
module pdcs_err_gate
   import pdcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire pdcs_err_evt_t evt,
   input wire logic ur_en,
   input wire logic fatal_en,
   input wire logic nonfatal_en,
   input wire logic cor_en,
   output pdcs_err_msg_t msg
);
   pdcs_err_msg_t msg_nxt;
   // Unsupported request maps to nonfatal severity, reported only if both its own enable and the nonfatal enable are set
   assign msg_nxt.err_fatal = evt.fatal & fatal_en;
   assign msg_nxt.err_nonfatal = (evt.nonfatal & nonfatal_en) |
      (evt.unsupported & ur_en & nonfatal_en);
   assign msg_nxt.err_cor = evt.correctable & cor_en;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         msg <= '0;
      else
         msg <= msg_nxt;
   end
endmodule : pdcs_err_gate

/* src/pdcs_pkg.sv */
// Purpose: Shared constants and carriers for the device control and status register block
// Assumes: 32-bit configuration data, dword addressed by byte offset
// Notes: Field positions follow the register layout exactly
package pdcs_pkg;
   localparam logic [11:0] PDCS_DEVICE_CONTROL_STATUS_OFS = 12'h0C8;
   localparam logic [31:0] PDCS_RESET_VALUE = 32'h0000_2000;
   localparam int PDCS_BIT_PENDING = 21;
   localparam int PDCS_BIT_AUX_SEEN = 20;
   localparam int PDCS_BIT_UR_FLAG = 19;
   localparam int PDCS_BIT_FATAL_FLAG = 18;
   localparam int PDCS_BIT_NONFATAL_FLAG = 17;
   localparam int PDCS_BIT_COR_FLAG = 16;
   localparam int PDCS_BIT_RETRY_EN = 15;
   localparam int PDCS_RDSIZE_LSB = 12;
   localparam int PDCS_BIT_AUX_DRAW = 10;
   localparam int PDCS_PAYLOAD_LSB = 5;
   localparam int PDCS_BIT_UR_REPORT = 3;
   localparam int PDCS_BIT_FATAL_REPORT = 2;
   localparam int PDCS_BIT_NONFATAL_REPORT = 1;
   localparam int PDCS_BIT_COR_REPORT = 0;
   localparam logic [2:0] PDCS_RDSIZE_RESET = 3'h2;
   localparam logic [2:0] PDCS_RDSIZE_MAX_LEGAL = 3'h5;
   localparam logic [2:0] PDCS_PAYLOAD_RESET = 3'h0;
   localparam logic [2:0] PDCS_PAYLOAD_SUPPORTED = 3'h0;
   localparam logic [12:0] PDCS_PAYLOAD_BYTES = 13'h0080;
   localparam logic [12:0] PDCS_RDSIZE_BASE_BYTES = 13'h0080;

   // Configuration access from the core's configuration decoder
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [3:0] be;
   } pdcs_cfg_req_t;

   // Error events detected elsewhere in the bridge, one-cycle pulses
   typedef struct packed {
      logic unsupported;
      logic fatal;
      logic nonfatal;
      logic correctable;
   } pdcs_err_evt_t;

   // Message requests toward the link transmitter
   typedef struct packed {
      logic err_fatal;
      logic err_nonfatal;
      logic err_cor;
   } pdcs_err_msg_t;

   function automatic logic [12:0] pdcs_rdsize_bytes(input logic [2:0] code);
      pdcs_rdsize_bytes = PDCS_RDSIZE_BASE_BYTES << code;
   endfunction : pdcs_rdsize_bytes
endpackage : pdcs_pkg

/* src/pdcs_top.sv */
// Purpose: Device control and status register of the bridge capability structure
// Assumes: Configuration accesses arrive as single-cycle strobes on the core clock
// Notes: Read data is registered, valid one cycle after the read strobe
// How it works
// - Bits 31 to 22 read zero, writes ignored.
// - Bit 21 shows outstanding non-posted requests awaiting completion.
// - Bit 20 shows whether auxiliary power is detected.
// - Bit 19 sets on unsupported request, cleared by writing one.
// - Bit 18 sets on fatal error, cleared by writing one.
// - Bit 17 sets on non-fatal error, cleared by writing one.
// - Bit 16 sets on correctable error, cleared by writing one.
// - Bit 15 enables retry status for configuration requests below bridge.
// - Bits 14:12 limit read request size, reset 010, 110/111 reserved.
// - No snoop never used; bit 11 reads zero.
// - Bit 10 read-write, reset zero, allows extra auxiliary power draw.
// - Phantom functions unused; bit 9 reads zero.
// - Extended tags unsupported; bit 8 reads zero.
// - Bits 7:5 read-write payload size, reset 000, always 128 bytes.
// - Relaxed ordering disabled; bit 4 reads zero.
// - Unsupported request reporting only when bits 3 and 1 are both set.
// - Fatal messages only when bit 2 set.
// - Non-fatal messages only when bit 1 set.
// - Correctable messages only when bit 0 set.
// - Payload limit output stays at the supported 128 bytes for any programmed code.
`timescale 1ns/1ps
module pdcs_top
   import pdcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire pdcs_cfg_req_t cfg_req,
   input wire pdcs_err_evt_t err_evt,
   input wire logic nonposted_outstanding,
   input wire logic aux_supply_seen,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   output pdcs_err_msg_t err_msg,
   output logic config_retry_enable,
   output logic [12:0] read_request_limit_bytes,
   output logic [12:0] payload_limit_bytes,
   output logic aux_supply_draw_enable,
   output logic no_snoop_enable,
   output logic relaxed_ordering_enable,
   output logic phantom_function_enable,
   output logic extended_tag_enable
);
   logic retry_en_r;
   logic [2:0] rdsize_r;
   logic [2:0] payload_limit_r;
   logic aux_draw_r;
   logic ur_report_r;
   logic fatal_report_r;
   logic nonfatal_report_r;
   logic cor_report_r;
   logic pending_r;
   logic aux_seen_r;
   logic [3:0] flags;
   logic [31:0] rdata_nxt;
   logic [31:0] reg_word;

   wire hit = (cfg_req.addr == PDCS_DEVICE_CONTROL_STATUS_OFS);
   wire wr_hit = cfg_req.wr & hit;
   wire rd_hit = cfg_req.rd & hit;
   wire wr_b0 = wr_hit & cfg_req.be[0];
   wire wr_b1 = wr_hit & cfg_req.be[1];
   wire wr_b2 = wr_hit & cfg_req.be[2];
   wire [2:0] wr_rdsize = cfg_req.wdata[PDCS_RDSIZE_LSB +: 3];
   // Reserved codes are refused so the limit always names a legal size
   wire rdsize_ok = (wr_rdsize <= PDCS_RDSIZE_MAX_LEGAL);
   wire [3:0] evt_vec = {err_evt.unsupported, err_evt.fatal, err_evt.nonfatal,
      err_evt.correctable};
   wire [3:0] clr_vec = {4{wr_b2}} & cfg_req.wdata[PDCS_BIT_UR_FLAG:PDCS_BIT_COR_FLAG];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_flag
         pdcs_w1c_flag u_flag (
            .clock(clock),
            .rst_n(rst_n),
            .set_evt(evt_vec[gi]),
            .clr_w1(clr_vec[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   pdcs_err_gate u_gate (
      .clock(clock),
      .rst_n(rst_n),
      .evt(err_evt),
      .ur_en(ur_report_r),
      .fatal_en(fatal_report_r),
      .nonfatal_en(nonfatal_report_r),
      .cor_en(cor_report_r),
      .msg(err_msg)
   );

   // Read-write fields; flags and status bits are held elsewhere, the other bits of the word are never stored
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         retry_en_r <= 1'b0;
         rdsize_r <= PDCS_RDSIZE_RESET;
         payload_limit_r <= PDCS_PAYLOAD_RESET;
         aux_draw_r <= 1'b0;
         ur_report_r <= 1'b0;
         fatal_report_r <= 1'b0;
         nonfatal_report_r <= 1'b0;
         cor_report_r <= 1'b0;
      end
      else
      begin
         if (wr_b1)
         begin
            retry_en_r <= cfg_req.wdata[PDCS_BIT_RETRY_EN];
            if (rdsize_ok)
               rdsize_r <= wr_rdsize;
            aux_draw_r <= cfg_req.wdata[PDCS_BIT_AUX_DRAW];
         end
         if (wr_b0)
         begin
            payload_limit_r <= cfg_req.wdata[PDCS_PAYLOAD_LSB +: 3];
            ur_report_r <= cfg_req.wdata[PDCS_BIT_UR_REPORT];
            fatal_report_r <= cfg_req.wdata[PDCS_BIT_FATAL_REPORT];
            nonfatal_report_r <= cfg_req.wdata[PDCS_BIT_NONFATAL_REPORT];
            cor_report_r <= cfg_req.wdata[PDCS_BIT_COR_REPORT];
         end
      end
   end

   // Status inputs are registered so reads show a stable sample
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pending_r <= 1'b0;
         aux_seen_r <= 1'b0;
      end
      else
      begin
         pending_r <= nonposted_outstanding;
         aux_seen_r <= aux_supply_seen;
      end
   end

   always_comb
   begin
      reg_word = '0;
      reg_word[PDCS_BIT_PENDING] = pending_r;
      reg_word[PDCS_BIT_AUX_SEEN] = aux_seen_r;
      reg_word[PDCS_BIT_UR_FLAG:PDCS_BIT_COR_FLAG] = flags;
      reg_word[PDCS_BIT_RETRY_EN] = retry_en_r;
      reg_word[PDCS_RDSIZE_LSB +: 3] = rdsize_r;
      reg_word[PDCS_BIT_AUX_DRAW] = aux_draw_r;
      reg_word[PDCS_PAYLOAD_LSB +: 3] = payload_limit_r;
      reg_word[PDCS_BIT_UR_REPORT] = ur_report_r;
      reg_word[PDCS_BIT_FATAL_REPORT] = fatal_report_r;
      reg_word[PDCS_BIT_NONFATAL_REPORT] = nonfatal_report_r;
      reg_word[PDCS_BIT_COR_REPORT] = cor_report_r;
   end

   // Unmapped reads return zero
   assign rdata_nxt = rd_hit ? reg_word : 32'h0000_0000;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cfg_rdata <= 32'h0000_0000;
         cfg_rvalid <= 1'b0;
         config_retry_enable <= 1'b0;
         // Match the reset read size code so the limit never shows a transient value
         read_request_limit_bytes <= pdcs_rdsize_bytes(PDCS_RDSIZE_RESET);
         payload_limit_bytes <= PDCS_PAYLOAD_BYTES;
         aux_supply_draw_enable <= 1'b0;
         no_snoop_enable <= 1'b0;
         relaxed_ordering_enable <= 1'b0;
         phantom_function_enable <= 1'b0;
         extended_tag_enable <= 1'b0;
      end
      else
      begin
         cfg_rdata <= rdata_nxt;
         cfg_rvalid <= cfg_req.rd;
         config_retry_enable <= retry_en_r;
         read_request_limit_bytes <= pdcs_rdsize_bytes(rdsize_r);
         // Only 128 bytes is supported, so every code yields the same limit
         payload_limit_bytes <= PDCS_PAYLOAD_BYTES;
         aux_supply_draw_enable <= aux_draw_r;
         no_snoop_enable <= 1'b0;
         relaxed_ordering_enable <= 1'b0;
         phantom_function_enable <= 1'b0;
         extended_tag_enable <= 1'b0;
      end
   end

   chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
      cfg_rvalid |-> cfg_rdata[31:22] == 10'h000)
      else $error("reserved bits nonzero");
   chk_pending_track: assert property (@(posedge clock) disable iff (!rst_n)
      rd_hit |=> cfg_rdata[PDCS_BIT_PENDING] == $past(pending_r))
      else $error("pending wrong");
   chk_aux_seen: assert property (@(posedge clock) disable iff (!rst_n)
      aux_supply_seen ##1 rd_hit |=> cfg_rdata[PDCS_BIT_AUX_SEEN])
      else $error("aux bit wrong");
   chk_ur_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      err_evt.unsupported ##1 rd_hit |=> cfg_rdata[PDCS_BIT_UR_FLAG])
      else $error("ur flag lost");
   chk_fatal_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (clr_vec[2] && !err_evt.fatal) |=> !flags[2])
      else $error("fatal flag kept");
   chk_rdsize_legal: assert property (@(posedge clock) disable iff (!rst_n)
      rdsize_r <= PDCS_RDSIZE_MAX_LEGAL)
      else $error("reserved read size");
   chk_ur_gate: assert property (@(posedge clock) disable iff (!rst_n)
      (err_msg.err_nonfatal && !$past(err_evt.nonfatal)) |-> $past(ur_report_r))
      else $error("ur sent while off");
   chk_fatal_gate: assert property (@(posedge clock) disable iff (!rst_n)
      err_msg.err_fatal |-> $past(fatal_report_r) && $past(err_evt.fatal))
      else $error("fatal sent");
   chk_cor_gate: assert property (@(posedge clock) disable iff (!rst_n)
      err_msg.err_cor |-> $past(cor_report_r))
      else $error("cor sent while off");
   chk_nonfatal_gate: assert property (@(posedge clock) disable iff (!rst_n)
      err_msg.err_nonfatal |-> $past(nonfatal_report_r))
      else $error("nonfatal sent");
   chk_payload_fixed: assert property (@(posedge clock) disable iff (!rst_n)
      payload_limit_bytes == PDCS_PAYLOAD_BYTES)
      else $error("payload over limit");
endmodule : pdcs_top

/* src/pdcs_w1c_flag.sv */
// Purpose: One sticky error flag, set by hardware, cleared by writing one
// Assumes: Event and clear are synchronous single-cycle strobes
// Notes: A set in the clearing cycle wins so no event is lost
`timescale 1ns/1ps
module pdcs_w1c_flag
   import pdcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic set_evt,
   input wire logic clr_w1,
   output logic flag
);
   logic flag_nxt;
   assign flag_nxt = set_evt | (flag & ~clr_w1);
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         flag <= 1'b0;
      else
         flag <= flag_nxt;
   end

   chk_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
      set_evt |=> flag) else $error("flag missed an event");
   chk_zero_keeps: assert property (@(posedge clock) disable iff (!rst_n)
      (flag && !clr_w1) |=> flag) else $error("flag lost without clear");
endmodule : pdcs_w1c_flag

/* verif/pcie_device_control_status_bench.sv */
// Purpose: Self-checking bench for the device control and status register
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Table rows cover writable fields; hand tests cover status, flags and messages
`timescale 1ns/1ps
module pcie_device_control_status_bench;
   import pdcs_pkg::*;
   typedef struct packed {logic [31:0] wdata; logic [3:0] be; logic [31:0] exp;} pdcs_row_t;
   localparam logic [11:0] REG_OFS = PDCS_DEVICE_CONTROL_STATUS_OFS;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   pdcs_cfg_req_t req = '0;
   pdcs_err_evt_t evt;
   pdcs_err_msg_t msg;
   logic nonposted_outstanding = 1'b0;
   logic aux_supply_seen = 1'b0;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid, config_retry_enable, aux_supply_draw_enable, no_snoop_enable;
   logic relaxed_ordering_enable, phantom_function_enable, extended_tag_enable;
   logic [12:0] read_request_limit_bytes, payload_limit_bytes;
   logic [31:0] rd_val;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   // Reserved read size code 111 in row 0 must leave the reset code in place
   pdcs_row_t rows[6] = '{'{32'hFFFFFFFF, 4'hF, 32'h0000A4EF}, '{32'h00005000, 4'hF, 32'h00005000},
      '{32'h000000FF, 4'h1, 32'h000050EF}, '{32'h00000000, 4'h2, 32'h000000EF},
      '{32'h00000000, 4'h1, 32'h00000000}, '{32'h00002000, 4'hF, 32'h00002000}};
   pdcs_top dut_u (.clock(clock), .rst_n(rst_n), .cfg_req(req), .err_evt(evt),
      .nonposted_outstanding(nonposted_outstanding), .aux_supply_seen(aux_supply_seen),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .err_msg(msg),
      .config_retry_enable(config_retry_enable), .read_request_limit_bytes(read_request_limit_bytes),
      .payload_limit_bytes(payload_limit_bytes), .aux_supply_draw_enable(aux_supply_draw_enable),
      .no_snoop_enable(no_snoop_enable), .relaxed_ordering_enable(relaxed_ordering_enable),
      .phantom_function_enable(phantom_function_enable), .extended_tag_enable(extended_tag_enable));
   pdcs_link_model link_u (.clock(clock), .rst_n(rst_n), .err_msg(msg), .err_evt(evt));
   initial
   begin
      forever #50 clock = ~clock;
   end
   task automatic tick;
      @(posedge clock);
      #1;
   endtask : tick
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic cfg_write(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] be);
      req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data, be: be};
      tick();
      req.wr = 1'b0;
      tick();
   endtask : cfg_write
   task automatic cfg_read(input logic [11:0] addr, output logic [31:0] data);
      req.rd = 1'b1;
      req.addr = addr;
      tick();
      req.rd = 1'b0;
      check({31'h0, cfg_rvalid}, 32'h1);
      data = cfg_rdata;
      tick();
   endtask : cfg_read
   task automatic expect_reg(input logic [31:0] exp);
      cfg_read(REG_OFS, rd_val);
      check(rd_val, exp);
   endtask : expect_reg
   task automatic check_msgs(input int f, input int nf, input int c);
      check(32'(link_u.fatal_seen), 32'(f));
      check(32'(link_u.nonfatal_seen), 32'(nf));
      check(32'(link_u.cor_seen), 32'(c));
   endtask : check_msgs
   task automatic check_side(input logic [31:0] word);
      check({31'h0, config_retry_enable}, {31'h0, word[15]});
      check({19'h0, read_request_limit_bytes}, {19'h0, 13'h0080 << word[14:12]});
      check({19'h0, payload_limit_bytes}, 32'h00000080);
      check({31'h0, aux_supply_draw_enable}, {31'h0, word[10]});
      check({28'h0, no_snoop_enable, relaxed_ordering_enable, phantom_function_enable,
         extended_tag_enable}, 32'h0);
   endtask : check_side
   task automatic pulse(input pdcs_err_evt_t kind);
      link_u.fire(kind);
      tick();
      link_u.fire(4'h0);
      tick();
   endtask : pulse
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (3) tick();
      rst_n = 1'b1;
      expect_reg(PDCS_RESET_VALUE);
      check_side(PDCS_RESET_VALUE);
      foreach (rows[i])
      begin
         cfg_write(REG_OFS, rows[i].wdata, rows[i].be);
         expect_reg(rows[i].exp);
         check_side(rows[i].exp);
      end
      cfg_write(12'h0CC, 32'hFFFFFFFF, 4'hF);
      expect_reg(32'h00002000);
      cfg_read(12'h0CC, rd_val);
      check(rd_val, 32'h0);
      nonposted_outstanding = 1'b1;
      aux_supply_seen = 1'b1;
      cfg_write(REG_OFS, 32'hFFF00000, 4'hC);
      expect_reg(32'h00302000);
      nonposted_outstanding = 1'b0;
      tick();
      expect_reg(32'h00102000);
      aux_supply_seen = 1'b0;
      pulse(4'hF);
      expect_reg(32'h000F2000);
      check_msgs(0, 0, 0);
      cfg_write(REG_OFS, 32'h00002000, 4'h4);
      expect_reg(32'h000F2000);
      cfg_write(REG_OFS, 32'h00082000, 4'h4);
      expect_reg(32'h00072000);
      // Clear and a new fatal event on the same edge: the flag must survive
      // The write strobe must drop after one edge or a second clear would follow
      req = '{rd: 1'b0, wr: 1'b1, addr: REG_OFS, wdata: 32'h00040000, be: 4'h4};
      link_u.fire(4'h4);
      tick();
      req.wr = 1'b0;
      link_u.fire(4'h0);
      tick();
      expect_reg(32'h00072000);
      cfg_write(REG_OFS, 32'h000F0000, 4'h4);
      expect_reg(32'h00002000);
      cfg_write(REG_OFS, 32'h0000000F, 4'h1);
      for (int k = 0; k < 4; k++)
         pulse(pdcs_err_evt_t'(4'h1 << k));
      check_msgs(1, 2, 1);
      cfg_write(REG_OFS, 32'h00000008, 4'h1);
      pulse(4'hF);
      check_msgs(1, 2, 1);
      // Non-fatal reporting on but unsupported reporting off
      cfg_write(REG_OFS, 32'h00000002, 4'h1);
      pulse(4'h8);
      check_msgs(1, 2, 1);
      pulse(4'h2);
      check_msgs(1, 3, 1);
      rst_n = 1'b0;
      repeat (2) tick();
      rst_n = 1'b1;
      expect_reg(PDCS_RESET_VALUE);
      check_side(PDCS_RESET_VALUE);
      wrap_up();
   end
endmodule : pcie_device_control_status_bench

/* verif/pdcs_link_model.sv */
// Purpose: Far-side model that raises detected-error events and counts message requests
// Assumes: The bench calls fire just after a rising edge
// Notes: Counters only grow; the bench compares totals
`timescale 1ns/1ps
module pdcs_link_model
   import pdcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire pdcs_err_msg_t err_msg,
   output pdcs_err_evt_t err_evt
);
   int fatal_seen = 0;
   int nonfatal_seen = 0;
   int cor_seen = 0;
   initial err_evt = '0;
   task automatic fire(input pdcs_err_evt_t kind);
      err_evt = kind;
   endtask : fire
   always @(posedge clock)
   begin
      if (rst_n === 1'b1)
      begin
         fatal_seen += (err_msg.err_fatal === 1'b1);
         nonfatal_seen += (err_msg.err_nonfatal === 1'b1);
         cor_seen += (err_msg.err_cor === 1'b1);
      end
   end
endmodule : pdcs_link_model
